// >>> verilog/fpag_pkg.sv
// Shared constants and carrier types of the flash port access guard.
// Assumes a 250 MHz core clock and a serial flash with 8-bit command, 24-bit address.
package fpag_pkg;
	localparam int unsigned CORE_MHZ       = 250;
	localparam int unsigned MASK_LIMIT_US  = 220;
	localparam int unsigned MASK_LIMIT_CYC = MASK_LIMIT_US * CORE_MHZ;
	localparam int unsigned SCK_HALF_CYC   = 2;
	localparam int unsigned ADDR_W         = 24;
	localparam int unsigned DATA_W         = 32;
	localparam int unsigned TAG_W          = 8;
	localparam logic [7:0]  FETCH_CMD      = 8'h03;
	localparam logic [6:0]  FETCH_BITS     = 7'h40;
	localparam logic [6:0]  SW_BITS        = 7'h08;
	localparam logic [7:0]  TAG_RESET      = 8'h00;

	typedef struct packed {
		logic              req;
		logic [ADDR_W-1:0] addr;
	} fpag_fetch_t;

	typedef struct packed {
		logic             valid;
		logic [7:0]       data;
	} fpag_byte_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_SW,
		ST_GAP
	} fpag_state_t;
endpackage

// >>> verilog/fpag_link.sv
// Link-clock side of the receive and transmit sequencers.
// Assumes link_rst is synchronous to link_clk; ack_tog comes from the core domain.
`timescale 1ns/10ps
module fpag_link #(
	parameter int unsigned TAG_W = 8
) (
	input  wire logic             link_clk,
	input  wire logic             link_rst,
	input  wire logic             link_rx_done,
	input  wire logic [TAG_W-1:0] link_rx_tag,
	input  wire logic             ack_tog,
	output logic                  rx_tog,
	output logic [TAG_W-1:0]      rx_tag,
	output logic                  link_tx_start
);
	logic             rx_tog_reg, rx_tog_next;
	logic [TAG_W-1:0] rx_tag_reg, rx_tag_next;
	logic             ack_s1_reg, ack_s2_reg, ack_s3_reg;
	logic             tx_start_reg, tx_start_next;

	// Receive events raise a toggle; transmit advances only on serviced interrupts
	always_comb begin
		rx_tog_next   = rx_tog_reg;
		rx_tag_next   = rx_tag_reg;
		tx_start_next = ack_s2_reg ^ ack_s3_reg; // [RULE11]
		if (link_rx_done) begin
			rx_tog_next = ~rx_tog_reg; // [RULE11]
			rx_tag_next = link_rx_tag;
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			rx_tog_reg   <= 1'b0;
			rx_tag_reg   <= {TAG_W{1'b0}};
			ack_s1_reg   <= 1'b0;
			ack_s2_reg   <= 1'b0;
			ack_s3_reg   <= 1'b0;
			tx_start_reg <= 1'b0;
		end else begin
			rx_tog_reg   <= rx_tog_next;
			rx_tag_reg   <= rx_tag_next;
			ack_s1_reg   <= ack_tog;
			ack_s2_reg   <= ack_s1_reg;
			ack_s3_reg   <= ack_s2_reg;
			tx_start_reg <= tx_start_next;
		end
	end

	assign rx_tog        = rx_tog_reg;
	assign rx_tag        = rx_tag_reg;
	assign link_tx_start = tx_start_reg;
endmodule

// >>> verilog/fpag_guard.sv
// Flash port access guard: fetch engine, software frames, pending receive interrupt.
// Assumes fetch and software requests are held until served; link events on link_clk.
// Operation
// RULE1 - Data moves only while select is low
// RULE2 - Next transaction waits for current to finish
// RULE3 - Fetch hardware launches reads on its own
// RULE4 - Arbitrate main and handler fetch requests
// RULE5 - Software frames its own select, command, data
// RULE6 - Transactions never split or interleaved
// RULE7 - Software masks interrupts around its frames
// RULE8 - Masked interrupt held, taken on release
// RULE9 - Single receive slot, later overwrites earlier
// RULE10 - Handler services every receive interrupt
// RULE11 - Link sequencers advance by interrupt tasks
// RULE12 - Masked interval stays under 220us
// RULE13 - Fetches stalled while software holds select
`timescale 1ns/10ps
module fpag_guard #(
	parameter int unsigned MASK_LIMIT = fpag_pkg::MASK_LIMIT_CYC,
	parameter int unsigned SCK_HALF   = fpag_pkg::SCK_HALF_CYC
) (
	input  wire logic                            core_clk,
	input  wire logic                            sys_rst,
	input  wire logic                            link_clk,
	input  wire logic                            link_rst,
	input  wire fpag_pkg::fpag_fetch_t           fetch_main,
	input  wire fpag_pkg::fpag_fetch_t           fetch_irq,
	output logic                                 fetch_done,
	output logic                                 fetch_src_irq,
	output logic [fpag_pkg::DATA_W-1:0]          fetch_data,
	input  wire logic                            sw_sel_req,
	input  wire fpag_pkg::fpag_byte_t            sw_tx,
	output logic                                 sw_sel_active,
	output logic                                 sw_byte_done,
	output logic [7:0]                           sw_rx_byte,
	input  wire logic                            irq_mask,
	input  wire logic                            irq_ack,
	output logic                                 irq_take,
	output logic                                 irq_active,
	output logic [fpag_pkg::TAG_W-1:0]           irq_tag,
	output logic                                 mask_over_limit,
	output logic                                 flash_select_n,
	output logic                                 flash_sck,
	output logic                                 flash_serial_in,
	input  wire logic                            flash_serial_out,
	input  wire logic                            link_rx_done,
	input  wire logic [fpag_pkg::TAG_W-1:0]      link_rx_tag,
	output logic                                 link_tx_start
);
	fpag_pkg::fpag_state_t        state_reg, state_next;
	logic                         shift_reg, shift_next, sck_reg, sck_next;
	logic [6:0]                   bits_reg, bits_next;
	logic [15:0]                  div_reg, div_next;
	logic                         sel_n_reg, sel_n_next, sw_act_reg, sw_act_next;
	logic [63:0]                  tx_reg, tx_next;
	logic [31:0]                  rx_reg, rx_next, fdata_reg, fdata_next;
	logic                         fdone_reg, fdone_next, src_reg, src_next;
	logic                         bdone_reg, bdone_next;
	logic [7:0]                   brx_reg, brx_next;
	logic                         sdo_s1_reg, sdo_s2_reg, irq_ok, main_ok, half_end;
	logic                         rx_tog_l, tog_s1_reg, tog_s2_reg, tog_s3_reg, rx_ev;
	logic [fpag_pkg::TAG_W-1:0]   rx_tag_l, ptag_reg, ptag_next, itag_reg, itag_next;
	logic                         pend_reg, pend_next, take_reg, take_next;
	logic                         irq_act_reg, irq_act_next, ack_tog_reg, ack_tog_next;
	logic [31:0]                  mcnt_reg, mcnt_next;
	logic                         over_reg, over_next;
	// Serial input synchroniser
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sdo_s1_reg <= 1'b0;
			sdo_s2_reg <= 1'b0;
		end else begin
			sdo_s1_reg <= flash_serial_out;
			sdo_s2_reg <= sdo_s1_reg;
		end
	end
	assign irq_ok   = fetch_irq.req && irq_act_reg;
	assign main_ok  = fetch_main.req;
	assign half_end = (div_reg == 16'(SCK_HALF - 1));
	assign sw_act_next = (state_next == fpag_pkg::ST_SW) && !sel_n_next; // [RULE13]
	// Port sequencer: one frame at a time, software or fetch
	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bits_next  = bits_reg;
		div_next   = div_reg;
		sck_next   = sck_reg;
		sel_n_next = sel_n_reg;
		tx_next    = tx_reg;
		rx_next    = rx_reg;
		fdone_next = 1'b0;
		src_next   = src_reg;
		fdata_next = fdata_reg;
		bdone_next = 1'b0;
		brx_next   = brx_reg;
		if (shift_reg) begin
			div_next = half_end ? 16'h0000 : div_reg + 16'h0001;
			if (half_end && !sck_reg) begin
				sck_next = 1'b1; // [RULE1]
				rx_next  = {rx_reg[30:0], sdo_s2_reg};
			end else if (half_end) begin
				sck_next  = 1'b0;
				tx_next   = {tx_reg[62:0], 1'b0};
				bits_next = bits_reg - 7'h01;
				if (bits_reg == 7'h01)
					shift_next = 1'b0;
			end
		end
		case (state_reg)
			fpag_pkg::ST_IDLE: begin
				div_next = 16'h0000;
				if (sw_sel_req) begin
					state_next = fpag_pkg::ST_SW; // [RULE13]
					sel_n_next = 1'b0;
				end else if (irq_ok || main_ok) begin
					state_next = fpag_pkg::ST_FETCH; // [RULE3]
					src_next   = irq_ok; // [RULE4]
					tx_next    = {fpag_pkg::FETCH_CMD,
						irq_ok ? fetch_irq.addr : fetch_main.addr, 32'h00000000};
					bits_next  = fpag_pkg::FETCH_BITS;
					shift_next = 1'b1;
					sel_n_next = 1'b0; // [RULE1]
				end
			end
			fpag_pkg::ST_FETCH: begin
				if (shift_reg && !shift_next) begin
					fdone_next = 1'b1;
					fdata_next = rx_next;
					state_next = fpag_pkg::ST_GAP; // [RULE2]
					sel_n_next = 1'b1;
				end
			end
			fpag_pkg::ST_SW: begin
				if (shift_reg && !shift_next) begin
					bdone_next = 1'b1;
					brx_next   = rx_next[7:0];
				end else if (!shift_reg && sw_tx.valid && !bdone_reg) begin
					tx_next    = {sw_tx.data, 56'h00000000000000};
					bits_next  = fpag_pkg::SW_BITS;
					shift_next = 1'b1;
				end else if (!shift_reg && !sw_sel_req) begin
					state_next = fpag_pkg::ST_GAP; // [RULE6]
					sel_n_next = 1'b1;
				end
			end
			fpag_pkg::ST_GAP: begin
				div_next = div_reg + 16'h0001;
				if (half_end) begin
					state_next = fpag_pkg::ST_IDLE; // [RULE2]
					div_next   = 16'h0000;
				end
			end
			default: state_next = fpag_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= fpag_pkg::ST_IDLE;
			sw_act_reg <= 1'b0;
			shift_reg <= 1'b0;
			bits_reg  <= 7'h00;
			div_reg   <= 16'h0000;
			sck_reg   <= 1'b0;
			sel_n_reg <= 1'b1;
			tx_reg    <= 64'h0000000000000000;
			rx_reg    <= 32'h00000000;
			fdone_reg <= 1'b0;
			src_reg   <= 1'b0;
			fdata_reg <= 32'h00000000;
			bdone_reg <= 1'b0;
			brx_reg   <= 8'h00;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bits_reg  <= bits_next;
			div_reg   <= div_next;
			sck_reg   <= sck_next;
			sel_n_reg <= sel_n_next;
			tx_reg    <= tx_next;
			rx_reg    <= rx_next;
			fdone_reg <= fdone_next;
			src_reg   <= src_next;
			fdata_reg <= fdata_next;
			bdone_reg <= bdone_next;
			brx_reg   <= brx_next;
			sw_act_reg <= sw_act_next;
		end
	end
	// Receive interrupt slot, mask timer and link crossing
	fpag_link #(
		.TAG_W (fpag_pkg::TAG_W)
	) u_link (
		.link_clk      (link_clk),
		.link_rst      (link_rst),
		.link_rx_done  (link_rx_done),
		.link_rx_tag   (link_rx_tag),
		.ack_tog       (ack_tog_reg),
		.rx_tog        (rx_tog_l),
		.rx_tag        (rx_tag_l),
		.link_tx_start (link_tx_start)
	);
	assign rx_ev = tog_s2_reg ^ tog_s3_reg;
	always_comb begin
		pend_next    = pend_reg;
		ptag_next    = ptag_reg;
		itag_next    = itag_reg;
		take_next    = 1'b0;
		irq_act_next = irq_act_reg;
		ack_tog_next = ack_tog_reg;
		mcnt_next    = irq_mask ? mcnt_reg + ((mcnt_reg == 32'hFFFFFFFF) ? 32'h0 : 32'h1) : 32'h0;
		over_next    = irq_mask ? (over_reg || mcnt_reg == 32'(MASK_LIMIT - 1)) : 1'b0; // [RULE12]
		if (irq_act_reg && irq_ack) begin
			irq_act_next = 1'b0;
			ack_tog_next = ~ack_tog_reg; // [RULE11]
		end
		if (pend_reg && !irq_mask && !irq_act_reg) begin
			take_next    = 1'b1; // [RULE8]
			irq_act_next = 1'b1;
			itag_next    = ptag_reg;
			pend_next    = 1'b0;
		end
		if (rx_ev) begin
			pend_next = 1'b1; // [RULE9]
			ptag_next = rx_tag_l;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tog_s1_reg  <= 1'b0;
			tog_s2_reg  <= 1'b0;
			tog_s3_reg  <= 1'b0;
			pend_reg    <= 1'b0;
			ptag_reg    <= fpag_pkg::TAG_RESET;
			itag_reg    <= fpag_pkg::TAG_RESET;
			take_reg    <= 1'b0;
			irq_act_reg <= 1'b0;
			ack_tog_reg <= 1'b0;
			mcnt_reg    <= 32'h00000000;
			over_reg    <= 1'b0;
		end else begin
			tog_s1_reg  <= rx_tog_l;
			tog_s2_reg  <= tog_s1_reg;
			tog_s3_reg  <= tog_s2_reg;
			pend_reg    <= pend_next;
			ptag_reg    <= ptag_next;
			itag_reg    <= itag_next;
			take_reg    <= take_next;
			irq_act_reg <= irq_act_next;
			ack_tog_reg <= ack_tog_next;
			mcnt_reg    <= mcnt_next;
			over_reg    <= over_next;
		end
	end
	assign fetch_done      = fdone_reg;
	assign fetch_src_irq   = src_reg;
	assign fetch_data      = fdata_reg;
	assign sw_sel_active   = sw_act_reg;
	assign sw_byte_done    = bdone_reg;
	assign sw_rx_byte      = brx_reg;
	assign irq_take        = take_reg;
	assign irq_active      = irq_act_reg;
	assign irq_tag         = itag_reg;
	assign mask_over_limit = over_reg;
	assign flash_select_n  = sel_n_reg;
	assign flash_sck       = sck_reg;
	assign flash_serial_in = tx_reg[63];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sck_in_frame_a: assert property ($rose(sck_reg) |-> !sel_n_reg) // [RULE1]
		else $error("serial clock rose outside a frame");
	frame_gap_a: assert property ($rose(sel_n_reg) |-> sel_n_reg [*2]) // [RULE2]
		else $error("select high gap too short");
	fetch_launch_a: assert property ((state_reg == fpag_pkg::ST_IDLE && !sw_sel_req
		&& main_ok) |=> !sel_n_reg && shift_reg) // [RULE3]
		else $error("fetch not launched");
	irq_ctx_grant_a: assert property ((state_reg == fpag_pkg::ST_IDLE && !sw_sel_req
		&& irq_ok) |=> src_reg) // [RULE4]
		else $error("handler fetch not preferred");
	sw_hold_select_a: assert property ((state_reg == fpag_pkg::ST_SW && shift_reg)
		|=> !sel_n_reg && state_reg == fpag_pkg::ST_SW) // [RULE6]
		else $error("software frame split");
	no_fetch_sw_a: assert property (sw_sel_active |-> !fdone_reg
		##1 state_reg != fpag_pkg::ST_FETCH) // [RULE13]
		else $error("fetch during software frame");
	pend_held_a: assert property ((pend_reg && irq_mask) |=> pend_reg && !take_reg) // [RULE8]
		else $error("pending interrupt lost while masked");
	take_on_release_a: assert property ((pend_reg && !irq_mask && !irq_act_reg)
		|=> take_reg && irq_act_reg && irq_tag == $past(ptag_reg)) // [RULE8]
		else $error("pending interrupt not taken");
	slot_overwrite_a: assert property (rx_ev |=> pend_reg && ptag_reg == $past(rx_tag_l)) // [RULE9]
		else $error("receive slot not overwritten");
	mask_limit_a: assert property ((irq_mask && mcnt_reg == 32'(MASK_LIMIT - 1))
		|=> mask_over_limit) // [RULE12]
		else $error("masked interval limit not flagged");
	fetch_done_c: cover property (fdone_reg && src_reg);
	sw_byte_c: cover property (bdone_reg ##[1:40] sel_n_reg);
	overwrite_c: cover property (pend_reg && irq_mask && rx_ev);
	take_c: cover property ($fell(irq_mask) ##1 take_reg);
endmodule

// >>> verif/fpag_flash_model.sv
// Behavioural serial flash on the far side of the guard's flash port.
// Assumes select, sck and serial data come from the guard; core_clk paces idle noise.
`timescale 1ns/10ps
module fpag_flash_model (
	input  wire logic   core_clk,
	input  wire logic   flash_select_n,
	input  wire logic   flash_sck,
	input  wire logic   flash_serial_in,
	output logic        flash_serial_out,
	output int          n_frames,
	output int          n_stray,
	output int          bits_last,
	output logic [31:0] hdr_last
);
	int          n_bits   = 0;
	logic [31:0] shift_in = 32'h0;
	logic [31:0] word     = 32'h0;
	logic        idle_bit = 1'b0;
	initial begin
		n_frames = 0;
		n_stray = 0;
		bits_last = 0;
		hdr_last = 32'h0;
	end
	// Released line shows a pattern that changes every cycle
	always @(posedge core_clk) idle_bit <= ~idle_bit;
	// Read data driven only inside a frame, after command and address
	assign flash_serial_out = (!flash_select_n && n_bits >= 32) ? word[31] : idle_bit;
	always @(negedge flash_select_n) begin
		n_bits = 0;
		n_frames++;
	end
	always @(posedge flash_select_n) begin
		bits_last = n_bits;
		hdr_last = shift_in;
	end
	always @(posedge flash_sck) begin
		if (flash_select_n) begin
			n_stray++;
		end else begin
			if (n_bits < 32) shift_in = {shift_in[30:0], flash_serial_in};
			if (n_bits == 31) word = {8'hC3, shift_in[23:0]};
			else word = {word[30:0], 1'b0};
			n_bits++;
		end
	end
endmodule

// >>> verif/tb.sv
// Self-checking bench of the flash port access guard.
// Assumes the behavioural flash on the port and a free-running 30 ns link clock.
`timescale 1ns/10ps
module tb;
	logic                        core_clk;
	logic                        sys_rst;
	logic                        link_clk;
	logic                        link_rst;
	fpag_pkg::fpag_fetch_t       fetch_main;
	fpag_pkg::fpag_fetch_t       fetch_irq;
	logic                        fetch_done;
	logic                        fetch_src_irq;
	logic [fpag_pkg::DATA_W-1:0] fetch_data;
	logic                        sw_sel_req;
	fpag_pkg::fpag_byte_t        sw_tx;
	logic                        sw_sel_active;
	logic                        sw_byte_done;
	logic [7:0]                  sw_rx_byte;
	logic                        irq_mask;
	logic                        irq_ack;
	logic                        irq_take;
	logic                        irq_active;
	logic [fpag_pkg::TAG_W-1:0]  irq_tag;
	logic                        mask_over_limit;
	logic                        flash_select_n;
	logic                        flash_sck;
	logic                        flash_serial_in;
	logic                        flash_serial_out;
	logic                        link_rx_done;
	logic [fpag_pkg::TAG_W-1:0]  link_rx_tag;
	logic                        link_tx_start;
	logic [31:0]                 hdr_last;
	int                          n_fail = 0, checked = 0, n_done = 0, n_take = 0, n_tx = 0;
	int                          cyc = 0, hi_run = 0, gap_last = 0, i;
	int                          n_frames, n_stray, bits_last;

	fpag_guard #(.MASK_LIMIT(50), .SCK_HALF(2)) i_dut (
		.core_clk, .sys_rst, .link_clk, .link_rst, .fetch_main, .fetch_irq, .fetch_done,
		.fetch_src_irq, .fetch_data, .sw_sel_req, .sw_tx, .sw_sel_active, .sw_byte_done,
		.sw_rx_byte, .irq_mask, .irq_ack, .irq_take, .irq_active, .irq_tag, .mask_over_limit,
		.flash_select_n, .flash_sck, .flash_serial_in, .flash_serial_out, .link_rx_done,
		.link_rx_tag, .link_tx_start
	);
	fpag_flash_model i_flash (
		.core_clk, .flash_select_n, .flash_sck, .flash_serial_in, .flash_serial_out,
		.n_frames, .n_stray, .bits_last, .hdr_last
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// Pulse counters, select-high gap and hang limit
	always @(negedge core_clk) begin
		cyc++;
		if (fetch_done === 1'b1) n_done++;
		if (irq_take === 1'b1) n_take++;
		if (flash_select_n === 1'b1) hi_run++;
		else if (hi_run != 0) begin
			gap_last = hi_run;
			hi_run = 0;
		end
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	always @(negedge link_clk) if (link_tx_start === 1'b1) n_tx++;

	task automatic wrap_up();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_f(input logic got, input logic exp);
		chk_w({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wait_done();
		for (i = 0; i < 600 && fetch_done !== 1'b1; i++) @(negedge core_clk);
	endtask
	task automatic sw_byte(input logic [7:0] b);
		@(negedge core_clk) sw_tx = '{valid: 1'b1, data: b};
		for (i = 0; i < 100 && sw_byte_done !== 1'b1; i++) @(negedge core_clk);
		sw_tx.valid = 1'b0;
	endtask
	task automatic rx_event(input logic [7:0] t);
		@(negedge link_clk) link_rx_done = 1'b1;
		link_rx_tag = t;
		@(negedge link_clk) link_rx_done = 1'b0;
	endtask

	task automatic t_reset();
		chk_f(flash_select_n, 1'b1);
		chk_f(flash_sck, 1'b0);
		chk_f(irq_active, 1'b0);
		chk_f(sw_sel_active, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_fetch();
		@(negedge core_clk) fetch_main = '{req: 1'b1, addr: 24'h123456};
		wait_done();
		fetch_main.addr = 24'hFEDCBA;
		chk_w(fetch_data, 32'hC3123456);
		chk_f(fetch_src_irq, 1'b0);
		chk_w(hdr_last, 32'h03123456);
		@(negedge core_clk);
		wait_done();
		fetch_main.req = 1'b0;
		chk_w(fetch_data, 32'hC3FEDCBA);
		chk_w(bits_last, 32'd64);
		chk_f(gap_last >= 2, 1'b1);
		$display("test fetch done");
	endtask
	task automatic t_sw();
		int nf;
		int nd;
		@(negedge core_clk) irq_mask = 1'b1;
		sw_sel_req = 1'b1;
		for (i = 0; i < 20 && sw_sel_active !== 1'b1; i++) @(negedge core_clk);
		chk_f(sw_sel_active, 1'b1);
		fetch_main = '{req: 1'b1, addr: 24'h00ABCD};
		nf = n_frames;
		nd = n_done;
		sw_byte(8'h03);
		sw_byte(8'h00);
		sw_byte(8'hAB);
		sw_byte(8'hCD);
		sw_byte(8'h00);
		chk_w(sw_rx_byte, 8'hC3);
		chk_w(n_done, nd);
		chk_w(n_frames, nf);
		sw_sel_req = 1'b0;
		for (i = 0; i < 20 && flash_select_n !== 1'b1; i++) @(negedge core_clk);
		chk_f(sw_sel_active, 1'b0);
		irq_mask = 1'b0;
		chk_w(bits_last, 32'd40);
		chk_w(hdr_last, 32'h0300ABCD);
		wait_done();
		fetch_main.req = 1'b0;
		chk_w(fetch_data, 32'hC300ABCD);
		$display("test software frame done");
	endtask
	task automatic t_irq();
		@(negedge core_clk) irq_mask = 1'b1;
		rx_event(8'h11);
		repeat (4) @(negedge link_clk);
		rx_event(8'h22);
		repeat (10) @(negedge core_clk);
		chk_w(n_take, 0);
		irq_mask = 1'b0;
		for (i = 0; i < 10 && irq_take !== 1'b1; i++) @(negedge core_clk);
		chk_w(irq_tag, 8'h22);
		chk_f(irq_active, 1'b1);
		fetch_main = '{req: 1'b1, addr: 24'h000100};
		fetch_irq = '{req: 1'b1, addr: 24'h000200};
		wait_done();
		fetch_irq.req = 1'b0;
		chk_f(fetch_src_irq, 1'b1);
		chk_w(fetch_data, 32'hC3000200);
		@(negedge core_clk);
		wait_done();
		fetch_main.req = 1'b0;
		chk_f(fetch_src_irq, 1'b0);
		chk_w(fetch_data, 32'hC3000100);
		irq_ack = 1'b1;
		@(negedge core_clk) irq_ack = 1'b0;
		repeat (40) @(negedge core_clk);
		chk_f(irq_active, 1'b0);
		chk_w(n_take, 1);
		chk_w(n_tx, 1);
		$display("test interrupt done");
	endtask
	task automatic t_limit();
		@(negedge core_clk) irq_mask = 1'b1;
		repeat (45) @(negedge core_clk);
		chk_f(mask_over_limit, 1'b0);
		repeat (10) @(negedge core_clk);
		chk_f(mask_over_limit, 1'b1);
		irq_mask = 1'b0;
		repeat (3) @(negedge core_clk);
		chk_f(mask_over_limit, 1'b0);
		$display("test mask limit done");
	endtask

	initial begin
		sys_rst = 1'b1;
		link_rst = 1'b1;
		fetch_main = '0;
		fetch_irq = '0;
		sw_sel_req = 1'b0;
		sw_tx = '0;
		irq_mask = 1'b0;
		irq_ack = 1'b0;
		link_rx_done = 1'b0;
		link_rx_tag = 8'h00;
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		@(negedge link_clk) link_rst = 1'b0;
		@(negedge core_clk);
		t_reset();
		t_fetch();
		t_sw();
		t_irq();
		t_limit();
		chk_w(n_stray, 0);
		wrap_up();
	end
endmodule
